// ===== logic/mid_cfg.svh
// Constants of the instruction decoder: offsets, fields, reset values, timing
// What this block does
// - File operand is 7-bit address 0x00..0x7F
// - Destination bit 0 accumulator, 1 register
// - Bit index selects bit within byte
// - Instruction cycle lasts four clock periods
// - Taken test or branch costs NOP cycle
// - Top bits 00 byte, 01 bit, else literal/control
// - Add/sub/and/or/xor codes and their flags
// - Rotates through carry update only carry
// - Decrement/increment skip on zero, no flags
// - Complement, decrement, increment update zero only
// - Don't-care opcode bits are ignored
// - Bit clear, set, test-skip clear/set
// - Add/sub literal update carry, digit carry, zero
// - Literal and/or/xor update zero only
// - Call, jump and returns take two cycles
// - Return with literal loads accumulator, two cycles
// - Standby and watchdog clear touch timeout/powerdown
// - Write to timer count clears prescaler
// - Literals are 8-bit data, 11-bit targets
`ifndef MID_CFG_SVH
`define MID_CFG_SVH
// Register byte offsets
`define MID_OFF_CTRL 8'h00
`define MID_OFF_TADDR 8'h04
`define MID_OFF_STAT 8'h08
`define MID_OFF_CYCLES 8'h0C
// Reset values
`define MID_CTRL_RST 2'h0
`define MID_TADDR_RST 7'h01
// Clocks in one instruction cycle
`define MID_CYCLE_CLKS 4
// Instruction word fields
`define MID_CLS_HI 13
`define MID_CLS_LO 12
`define MID_SUB_HI 11
`define MID_SUB_LO 8
`define MID_DEST_BIT 7
`define MID_BIT_HI 9
`define MID_BIT_LO 7
`define MID_FILE_HI 6
`define MID_LIT8_HI 7
`define MID_LIT11_HI 10
// Fixed control words, low seven bits
`define MID_W_SLEEP 7'h63
`define MID_W_WDT 7'h64
`define MID_W_RETI 7'h09
`define MID_W_RET 7'h08
`endif

// ===== logic/mid_pkg.sv
// Types shared by the instruction decoder files
package mid_pkg;
  `include "mid_cfg.svh"

  // Operation decoded from one word
  typedef enum logic [5:0] {
    MID_OP_NOP, MID_OP_ADD_ACC_TO_REG, MID_OP_AND_ACC_WITH_REG, MID_OP_OR_ACC_WITH_REG,
    MID_OP_XOR_ACC_WITH_REG, MID_OP_SUB_ACC_FROM_REG, MID_OP_COMPLEMENT_REG,
    MID_OP_DECREMENT_REG, MID_OP_INCREMENT_REG, MID_OP_DECREMENT_SKIP_ZERO,
    MID_OP_INCREMENT_SKIP_ZERO, MID_OP_ROTATE_LEFT_CARRY, MID_OP_ROTATE_RIGHT_CARRY,
    MID_OP_CLEAR_REG, MID_OP_CLEAR_ACC, MID_OP_MOVE_REG, MID_OP_MOVE_ACC_TO_REG,
    MID_OP_SWAP_NIBBLES, MID_OP_BIT_CLEAR_OP, MID_OP_BIT_SET_OP, MID_OP_TEST_SKIP_IF_CLEAR,
    MID_OP_TEST_SKIP_IF_SET, MID_OP_ADD_LITERAL, MID_OP_SUB_FROM_LITERAL, MID_OP_AND_LITERAL,
    MID_OP_OR_LITERAL, MID_OP_XOR_LITERAL, MID_OP_MOVE_LITERAL, MID_OP_CALL,
    MID_OP_UNCONDITIONAL_JUMP, MID_OP_RETURN, MID_OP_INTERRUPT_RETURN,
    MID_OP_RETURN_WITH_LITERAL, MID_OP_STANDBY, MID_OP_WATCHDOG_CLEAR, MID_OP_UNUSED
  } mid_op_t;

  // Class from the two top bits, in code order 00..11
  typedef enum logic [1:0] {MID_CLS_BYTE, MID_CLS_BIT, MID_CLS_CTRL, MID_CLS_LIT} mid_cls_t;

  // Condition that makes the instruction skip
  typedef enum logic [1:0] {MID_SK_NONE, MID_SK_ZERO, MID_SK_CLR, MID_SK_SET} mid_skip_t;

  // Status flags that the operation updates
  typedef struct packed {
    logic carry;
    logic digitCarry;
    logic zero;
    logic timeoutPowerdown;
  } mid_flags_t;

  // Full decode of one word
  typedef struct packed {
    mid_op_t op;
    mid_cls_t cls;
    logic [6:0] fileAddr;
    logic toReg;
    logic writesReg;
    logic [2:0] bitIdx;
    logic [10:0] literal;
    logic twoCycle;
    mid_skip_t skip;
    mid_flags_t flags;
  } mid_dec_t;

  // APB request and answer
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
  } mid_apb_req_t;

  typedef struct packed {
    logic pready;
    logic [31:0] prdata;
    logic pslverr;
  } mid_apb_rsp_t;

  // Sequencer states
  typedef enum logic {MID_ST_IDLE, MID_ST_RUN} mid_state_t;

  // Software controls
  typedef struct packed {
    logic prescToTimer;
    logic run;
  } mid_ctrl_t;
endpackage

// ===== logic/mid_op_decode.sv
// Combinational decode of one 14-bit instruction word
`timescale 1ns/10ps
`include "mid_cfg.svh"
module mid_op_decode (
  input wire logic [13:0] word,
  output mid_pkg::mid_dec_t dec
);
  import mid_pkg::*;

  // Fields first, then the operation by class
  always_comb begin
    dec = '0;
    dec.op = MID_OP_NOP;
    dec.cls = mid_cls_t'(word[`MID_CLS_HI:`MID_CLS_LO]);
    dec.fileAddr = word[`MID_FILE_HI:0];
    dec.toReg = word[`MID_DEST_BIT];
    dec.bitIdx = word[`MID_BIT_HI:`MID_BIT_LO];
    dec.literal = {3'h0, word[`MID_LIT8_HI:0]};
    dec.skip = MID_SK_NONE;
    case (dec.cls)
      MID_CLS_BYTE: begin
        dec.writesReg = word[`MID_DEST_BIT];
        case (word[`MID_SUB_HI:`MID_SUB_LO])
          4'h7: begin
            dec.op = MID_OP_ADD_ACC_TO_REG;
            dec.flags = '{1'b1, 1'b1, 1'b1, 1'b0};
          end
          4'h2: begin
            dec.op = MID_OP_SUB_ACC_FROM_REG;
            dec.flags = '{1'b1, 1'b1, 1'b1, 1'b0};
          end
          4'h5: begin
            dec.op = MID_OP_AND_ACC_WITH_REG;
            dec.flags.zero = 1'b1;
          end
          4'h4: begin
            dec.op = MID_OP_OR_ACC_WITH_REG;
            dec.flags.zero = 1'b1;
          end
          4'h6: begin
            dec.op = MID_OP_XOR_ACC_WITH_REG;
            dec.flags.zero = 1'b1;
          end
          4'hD: begin
            dec.op = MID_OP_ROTATE_LEFT_CARRY;
            dec.flags.carry = 1'b1;
          end
          4'hC: begin
            dec.op = MID_OP_ROTATE_RIGHT_CARRY;
            dec.flags.carry = 1'b1;
          end
          4'hB: begin
            dec.op = MID_OP_DECREMENT_SKIP_ZERO;
            dec.skip = MID_SK_ZERO;
          end
          4'hF: begin
            dec.op = MID_OP_INCREMENT_SKIP_ZERO;
            dec.skip = MID_SK_ZERO;
          end
          4'h9: begin
            dec.op = MID_OP_COMPLEMENT_REG;
            dec.flags.zero = 1'b1;
          end
          4'h3: begin
            dec.op = MID_OP_DECREMENT_REG;
            dec.flags.zero = 1'b1;
          end
          4'hA: begin
            dec.op = MID_OP_INCREMENT_REG;
            dec.flags.zero = 1'b1;
          end
          4'h8: begin
            dec.op = MID_OP_MOVE_REG;
            dec.flags.zero = 1'b1;
          end
          4'hE: dec.op = MID_OP_SWAP_NIBBLES;
          4'h1: begin
            // Clear acc ignores its low seven bits
            dec.op = word[`MID_DEST_BIT] ? MID_OP_CLEAR_REG : MID_OP_CLEAR_ACC;
            dec.flags.zero = 1'b1;
          end
          default: begin
            dec.writesReg = 1'b0;
            if (word[`MID_DEST_BIT]) begin
              dec.op = MID_OP_MOVE_ACC_TO_REG;
              dec.writesReg = 1'b1;
            end else if (word[6:0] == `MID_W_SLEEP) begin
              dec.op = MID_OP_STANDBY;
              dec.flags.timeoutPowerdown = 1'b1;
            end else if (word[6:0] == `MID_W_WDT) begin
              dec.op = MID_OP_WATCHDOG_CLEAR;
              dec.flags.timeoutPowerdown = 1'b1;
            end else if (word[6:0] == `MID_W_RET) begin
              dec.op = MID_OP_RETURN;
              dec.twoCycle = 1'b1;
            end else if (word[6:0] == `MID_W_RETI) begin
              dec.op = MID_OP_INTERRUPT_RETURN;
              dec.twoCycle = 1'b1;
            end else if (word[4:0] == 5'h00) begin
              dec.op = MID_OP_NOP;
            end else begin
              dec.op = MID_OP_UNUSED;
            end
          end
        endcase
      end
      MID_CLS_BIT: begin
        case (word[`MID_SUB_HI:10])
          2'h0: begin
            dec.op = MID_OP_BIT_CLEAR_OP;
            dec.writesReg = 1'b1;
          end
          2'h1: begin
            dec.op = MID_OP_BIT_SET_OP;
            dec.writesReg = 1'b1;
          end
          2'h2: begin
            dec.op = MID_OP_TEST_SKIP_IF_CLEAR;
            dec.skip = MID_SK_CLR;
          end
          default: begin
            dec.op = MID_OP_TEST_SKIP_IF_SET;
            dec.skip = MID_SK_SET;
          end
        endcase
        dec.toReg = dec.writesReg;
      end
      MID_CLS_CTRL: begin
        dec.op = word[`MID_SUB_HI] ? MID_OP_UNCONDITIONAL_JUMP : MID_OP_CALL;
        dec.literal = word[`MID_LIT11_HI:0];
        dec.twoCycle = 1'b1;
        dec.toReg = 1'b0;
      end
      default: begin
        dec.toReg = 1'b0;
        casez (word[`MID_SUB_HI:`MID_SUB_LO])
          4'b00??: dec.op = MID_OP_MOVE_LITERAL;
          4'b01??: begin
            dec.op = MID_OP_RETURN_WITH_LITERAL;
            dec.twoCycle = 1'b1;
          end
          4'b111?: begin
            dec.op = MID_OP_ADD_LITERAL;
            dec.flags = '{1'b1, 1'b1, 1'b1, 1'b0};
          end
          4'b110?: begin
            dec.op = MID_OP_SUB_FROM_LITERAL;
            dec.flags = '{1'b1, 1'b1, 1'b1, 1'b0};
          end
          4'b1001: begin
            dec.op = MID_OP_AND_LITERAL;
            dec.flags.zero = 1'b1;
          end
          4'b1000: begin
            dec.op = MID_OP_OR_LITERAL;
            dec.flags.zero = 1'b1;
          end
          4'b1010: begin
            dec.op = MID_OP_XOR_LITERAL;
            dec.flags.zero = 1'b1;
          end
          default: dec.op = MID_OP_UNUSED;
        endcase
      end
    endcase
  end
endmodule

// ===== logic/mid_decoder_top.sv
// Instruction sequencer: four-clock cycles, skip and flush, APB registers
`timescale 1ns/10ps
`include "mid_cfg.svh"
module mid_decoder_top (
  input wire logic clk,
  input wire logic rst_n,
  // Word from program memory, valid at the last clock of a cycle
  input wire logic [13:0] instrWord,
  // Addressed register contents and datapath result of the executing op
  input wire logic [7:0] operandByte,
  input wire logic [7:0] resultByte,
  input mid_pkg::mid_apb_req_t apbReq,
  output mid_pkg::mid_apb_rsp_t apbRsp,
  output mid_pkg::mid_dec_t execDec,
  output logic [1:0] execPhase,
  output logic fetchReq,
  output logic flushCycle,
  output logic zeroFlag,
  output logic prescClear
);
  import mid_pkg::*;

  // Last phase index of an instruction cycle
  localparam logic [1:0] LAST_PHASE = 2'(`MID_CYCLE_CLKS - 1);

  // All state of the sequencer
  typedef struct packed {
    mid_state_t state;
    logic [1:0] phase;
    mid_dec_t dec;
    logic flush;
    logic zero;
    logic presc;
    logic fetch;
    mid_ctrl_t ctrl;
    logic [6:0] timerAddr;
    logic [31:0] cycles;
    logic [13:0] lastWord;
    mid_apb_rsp_t rsp;
  } mid_seq_t;

  mid_seq_t s_r;
  mid_seq_t s_nxt;
  mid_dec_t wordDec; // Decode of the fetched word
  mid_dec_t nopDec; // Decode of an all-zero word, the flush filler
  logic lastPh; // Final clock of a running cycle
  logic testBit; // Bit picked by the executing bit index
  logic resultZero; // Result byte is all zero
  logic skipTaken; // Executing op turns the next cycle into a NOP
  logic apbAccess; // First access-phase clock
  logic apbDone; // Clock at which the master sees pready

  // Word decoder, and the same decoder producing the filler constant
  mid_op_decode uWord (
    .word(instrWord),
    .dec(wordDec)
  );

  mid_op_decode uNop (
    .word(14'h0000),
    .dec(nopDec)
  );

  assign lastPh = (s_r.state == MID_ST_RUN) && (s_r.phase == LAST_PHASE);
  assign testBit = operandByte[s_r.dec.bitIdx];
  assign resultZero = (resultByte == 8'h00);
  assign apbAccess = apbReq.psel && apbReq.penable && !s_r.rsp.pready;
  assign apbDone = apbReq.psel && apbReq.penable && s_r.rsp.pready;

  // Second cycle is needed on a branch or a true test
  always_comb begin
    skipTaken = s_r.dec.twoCycle;
    case (s_r.dec.skip)
      MID_SK_ZERO: skipTaken = resultZero;
      MID_SK_CLR: skipTaken = !testBit;
      MID_SK_SET: skipTaken = testBit;
      default: skipTaken = s_r.dec.twoCycle;
    endcase
  end

  // Next state: sequencer, flags, then the register bus
  always_comb begin
    s_nxt = s_r;
    s_nxt.fetch = 1'b0;
    s_nxt.presc = 1'b0;
    s_nxt.rsp.pready = 1'b0;
    s_nxt.rsp.pslverr = 1'b0;
    case (s_r.state)
      MID_ST_IDLE: begin
        s_nxt.phase = 2'h0;
        s_nxt.flush = 1'b0;
        s_nxt.dec = nopDec;
        // Start: first cycle runs a NOP while the first word arrives
        if (s_r.ctrl.run) begin
          s_nxt.state = MID_ST_RUN;
          s_nxt.fetch = 1'b1;
        end
      end
      MID_ST_RUN: begin
        // Two-bit phase wraps after four clocks
        s_nxt.phase = s_r.phase + 2'h1;
        if (lastPh) begin
          s_nxt.cycles = s_r.cycles + 32'h1;
          // Zero flag follows the datapath result
          if (s_r.dec.flags.zero) begin
            s_nxt.zero = resultZero;
          end
          // Any write-back to the timer count clears its prescaler
          if (s_r.dec.writesReg && (s_r.dec.fileAddr == s_r.timerAddr)
              && s_r.ctrl.prescToTimer) begin
            s_nxt.presc = 1'b1;
          end
          // Fetched word is dropped when the next cycle must be a NOP
          if (skipTaken) begin
            s_nxt.dec = nopDec;
            s_nxt.flush = 1'b1;
          end else begin
            s_nxt.dec = wordDec;
            s_nxt.flush = 1'b0;
          end
          s_nxt.lastWord = instrWord;
          // Stopping only at a cycle boundary keeps every op whole
          if (!s_r.ctrl.run) begin
            s_nxt.state = MID_ST_IDLE;
            s_nxt.dec = nopDec;
            s_nxt.flush = 1'b0;
          end else begin
            s_nxt.fetch = 1'b1;
          end
        end
      end
      default: s_nxt.state = MID_ST_IDLE;
    endcase
    // Bus answer one clock into the access phase
    if (apbAccess) begin
      s_nxt.rsp.pready = 1'b1;
      s_nxt.rsp.prdata = 32'h0000_0000;
      case (apbReq.paddr)
        `MID_OFF_CTRL: begin
          if (!apbReq.pwrite) begin
            s_nxt.rsp.prdata = {30'h0, s_r.ctrl};
          end
        end
        `MID_OFF_TADDR: begin
          if (!apbReq.pwrite) begin
            s_nxt.rsp.prdata = {25'h0, s_r.timerAddr};
          end
        end
        `MID_OFF_STAT: begin
          if (!apbReq.pwrite) begin
            s_nxt.rsp.prdata = {12'h0, s_r.phase, s_r.zero, s_r.flush,
                                2'h0, s_r.lastWord};
          end
        end
        `MID_OFF_CYCLES: begin
          if (!apbReq.pwrite) begin
            s_nxt.rsp.prdata = s_r.cycles;
          end
        end
        // Unmapped offsets answer with an error and zero data
        default: s_nxt.rsp.pslverr = 1'b1;
      endcase
    end
    // Writes land on the clock that completes the transfer
    if (apbDone && apbReq.pwrite) begin
      case (apbReq.paddr)
        `MID_OFF_CTRL: s_nxt.ctrl = mid_ctrl_t'(apbReq.pwdata[1:0]);
        `MID_OFF_TADDR: s_nxt.timerAddr = apbReq.pwdata[6:0];
        default: s_nxt.cycles = s_r.cycles;
      endcase
    end
  end

  // State register
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_r <= '0;
      s_r.ctrl <= `MID_CTRL_RST;
      s_r.timerAddr <= `MID_TADDR_RST;
    end else begin
      s_r <= s_nxt;
    end
  end

  // Outputs straight from the state register
  assign apbRsp = s_r.rsp;
  assign execDec = s_r.dec;
  assign execPhase = s_r.phase;
  assign fetchReq = s_r.fetch;
  assign flushCycle = s_r.flush;
  assign zeroFlag = s_r.zero;
  assign prescClear = s_r.presc;

  default clocking mcb @(posedge clk); endclocking
  default disable iff (!rst_n);

  // A cycle is four clocks from fetch to fetch
  AST_FOUR_CLOCKS: assert property (
    fetchReq |=> !fetchReq [*3] ##1 (fetchReq || s_r.state == MID_ST_IDLE))
    else $error("instruction cycle is not four clocks");

  // Filler cycle carries no operation
  AST_FLUSH_IS_NOP: assert property (
    flushCycle |-> execDec.op == MID_OP_NOP)
    else $error("flush cycle executes an operation");

  // Plain ops never produce a filler cycle
  AST_ONE_CYCLE: assert property (
    lastPh && !execDec.twoCycle && execDec.skip == MID_SK_NONE |=> !flushCycle)
    else $error("single-cycle op was followed by a flush");

  // Call and jump are followed by a filler while run stays set
  AST_BRANCH_TWO: assert property (
    lastPh && s_r.ctrl.run && (execDec.op == MID_OP_CALL
    || execDec.op == MID_OP_UNCONDITIONAL_JUMP) |=> flushCycle [*4])
    else $error("branch did not take two cycles");

  // Return and return with literal are two-cycle too
  AST_RETURN_TWO: assert property (
    lastPh && s_r.ctrl.run && (execDec.op == MID_OP_RETURN_WITH_LITERAL
    || execDec.op == MID_OP_RETURN) |=> flushCycle && execDec.op == MID_OP_NOP)
    else $error("return did not take two cycles");

  // Count skip follows a zero result
  AST_SKIP_ZERO: assert property (
    lastPh && s_r.ctrl.run && execDec.skip == MID_SK_ZERO
    |=> flushCycle == $past(resultZero))
    else $error("zero skip decision wrong");

  // Set-bit test skips on the selected bit
  AST_BIT_SKIP: assert property (
    lastPh && s_r.ctrl.run && execDec.skip == MID_SK_SET |=> flushCycle == $past(testBit))
    else $error("bit test skip decision wrong");

  // Zero flag reflects the result of a zero-updating op
  AST_ZERO_FLAG: assert property (
    lastPh && execDec.flags.zero |=> zeroFlag == $past(resultZero))
    else $error("zero flag not updated from result");

  // Prescaler clear is one clock after a timer write-back
  AST_PRESC_CLEAR: assert property (
    lastPh && execDec.writesReg && execDec.fileAddr == s_r.timerAddr
    && s_r.ctrl.prescToTimer |=> prescClear ##1 !prescClear)
    else $error("timer write did not clear prescaler once");

  // Bus answers one clock into the access phase
  AST_APB_WAIT: assert property (
    apbReq.psel && apbReq.penable && !apbRsp.pready |=> apbRsp.pready)
    else $error("register bus answer late");

  COV_BRANCH: cover property (lastPh && execDec.op == MID_OP_UNCONDITIONAL_JUMP ##1 flushCycle);
  COV_SKIP: cover property (lastPh && execDec.skip == MID_SK_ZERO ##1 flushCycle);
  COV_PRESC: cover property (prescClear);
  COV_APB_WRITE: cover property (apbDone && apbReq.pwrite);
endmodule

// ===== tb/mid_prog_mem.sv
// Program memory model: one 14-bit word per fetch request
`timescale 1ns/10ps
module mid_prog_mem (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic fetchReq,
  output logic [13:0] instrWord
);
  logic [13:0] prog [0:127]; // Program image, loaded by the bench
  logic [6:0] ptr_r; // Next word to hand out
  logic [13:0] word_r; // Word being fetched
  logic [1:0] cnt_r; // Clocks since the request
  // Word is valid only in the last clock of the cycle; elsewhere the lines
  // toggle, so a decoder that samples early cannot pass by luck
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ptr_r <= 7'h00;
      cnt_r <= 2'h0;
      word_r <= 14'h0000;
      instrWord <= 14'h0000;
    end else begin
      if (fetchReq) begin
        word_r <= prog[ptr_r];
        ptr_r <= ptr_r + 7'h01;
        cnt_r <= 2'h1;
      end else if (cnt_r != 2'h0) begin
        cnt_r <= cnt_r + 2'h1;
      end
      instrWord <= (cnt_r == 2'h2) ? word_r : ~instrWord;
    end
  end
endmodule

// ===== tb/mid_decoder_top_tb.sv
// Self-checking bench: program memory model, APB master, decode model
`timescale 1ns/10ps
module mid_decoder_top_tb;
  import mid_pkg::*;
  logic clk, rst_n; // Clock and reset
  logic [7:0] operandByte, resultByte; // Datapath side of the executing op
  logic [13:0] instrWord; // From the memory model
  mid_apb_req_t apbReq; // Register bus
  mid_apb_rsp_t apbRsp;
  mid_dec_t execDec; // Decoder outputs
  logic [1:0] execPhase;
  logic fetchReq, flushCycle, zeroFlag, prescClear;
  int errTotal, numChecks, seed, i, n, cur, pi;
  logic [31:0] rd;
  logic er, fl, expZ, expP, drop, first;
  logic [7:0] opB, resB;
  logic [13:0] w, cw;
  mid_dec_t ed;
  // Directed words: every operation code once, several aimed at address 0x15
  logic [13:0] dirW [0:34] = '{14'h0795, 14'h0515, 14'h0415, 14'h0615, 14'h0215,
    14'h0915, 14'h0315, 14'h0A15, 14'h0B15, 14'h0F15, 14'h0D15, 14'h0C15, 14'h0195,
    14'h0115, 14'h0815, 14'h0E15, 14'h0095, 14'h0060, 14'h0063, 14'h0064, 14'h1015,
    14'h1795, 14'h1A15, 14'h1F95, 14'h3E55, 14'h3C55, 14'h3955, 14'h3855, 14'h3A55,
    14'h3055, 14'h0008, 14'h0009, 14'h3455, 14'h2123, 14'h2ABC};

  mid_decoder_top mid_decoder_top_inst (.clk(clk), .rst_n(rst_n), .instrWord(instrWord),
    .operandByte(operandByte), .resultByte(resultByte), .apbReq(apbReq), .apbRsp(apbRsp),
    .execDec(execDec), .execPhase(execPhase), .fetchReq(fetchReq),
    .flushCycle(flushCycle), .zeroFlag(zeroFlag), .prescClear(prescClear));
  mid_prog_mem mid_prog_mem_inst (.clk(clk), .rst_n(rst_n), .fetchReq(fetchReq),
    .instrWord(instrWord));

  // Free-running 125 MHz clock
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  // Verdict and end of run, shared by the main flow and every timeout
  task automatic giveVerdict();
    if (errTotal == 0 && numChecks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  // Case-equal compare so an unknown never counts as a match
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    numChecks++;
    if (g !== e) begin
      errTotal++;
      $display("ERROR t=%0t got %h exp %h", $time, g, e);
    end
  endtask

  // One APB transfer; holds the request until pready is seen at an edge
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge clk);
    apbReq <= {1'b1, 1'b0, wr, a, d};
    @(posedge clk);
    apbReq.penable <= 1'b1;
    do begin
      @(posedge clk);
      k++;
    end while (apbRsp.pready !== 1'b1 && k < 20);
    rd = apbRsp.prdata;
    er = apbRsp.pslverr;
    apbReq <= '0;
    if (k >= 20) begin
      errTotal++;
      giveVerdict();
    end
  endtask

  // Bounded wait for the next fetch pulse; counts clocks waited
  task automatic waitFetch();
    n = 0;
    do begin
      @(posedge clk);
      #1;
      n++;
    end while (fetchReq !== 1'b1 && n < 50);
    if (n >= 50) begin
      errTotal++;
      giveVerdict();
    end
  endtask

  // Reference operation of a word, from the encoding rules
  function automatic mid_op_t expOp(input logic [13:0] w);
    if (w[13:12] == 2'b01) return mid_op_t'(w[11:10] + MID_OP_BIT_CLEAR_OP);
    if (w[13:12] == 2'b10) return w[11] ? MID_OP_UNCONDITIONAL_JUMP : MID_OP_CALL;
    if (w[13:12] == 2'b11) begin
      casez (w[11:8])
        4'b111?: return MID_OP_ADD_LITERAL;
        4'b110?: return MID_OP_SUB_FROM_LITERAL;
        4'h9: return MID_OP_AND_LITERAL;
        4'h8: return MID_OP_OR_LITERAL;
        4'hA: return MID_OP_XOR_LITERAL;
        4'b00??: return MID_OP_MOVE_LITERAL;
        4'b01??: return MID_OP_RETURN_WITH_LITERAL;
        default: return MID_OP_UNUSED;
      endcase
    end
    case (w[11:8])
      4'h7: return MID_OP_ADD_ACC_TO_REG;
      4'h5: return MID_OP_AND_ACC_WITH_REG;
      4'h4: return MID_OP_OR_ACC_WITH_REG;
      4'h6: return MID_OP_XOR_ACC_WITH_REG;
      4'h2: return MID_OP_SUB_ACC_FROM_REG;
      4'h9: return MID_OP_COMPLEMENT_REG;
      4'h3: return MID_OP_DECREMENT_REG;
      4'hA: return MID_OP_INCREMENT_REG;
      4'hB: return MID_OP_DECREMENT_SKIP_ZERO;
      4'hF: return MID_OP_INCREMENT_SKIP_ZERO;
      4'hD: return MID_OP_ROTATE_LEFT_CARRY;
      4'hC: return MID_OP_ROTATE_RIGHT_CARRY;
      4'h1: return w[7] ? MID_OP_CLEAR_REG : MID_OP_CLEAR_ACC;
      4'h8: return MID_OP_MOVE_REG;
      4'hE: return MID_OP_SWAP_NIBBLES;
      default: begin
        if (w[7]) return MID_OP_MOVE_ACC_TO_REG;
        if (w[6:0] == 7'h63) return MID_OP_STANDBY;
        if (w[6:0] == 7'h64) return MID_OP_WATCHDOG_CLEAR;
        if (w[6:0] == 7'h08) return MID_OP_RETURN;
        if (w[6:0] == 7'h09) return MID_OP_INTERRUPT_RETURN;
        if (w[4:0] == 5'h00) return MID_OP_NOP;
        return MID_OP_UNUSED;
      end
    endcase
  endfunction

  // Reference decode: flag masks, timing, skip kind, destination
  function automatic mid_dec_t expDec(input logic [13:0] w);
    mid_dec_t e;
    logic [3:0] b;
    logic [1:0] c;
    logic ar;
    e = '0;
    c = w[13:12];
    b = w[11:8];
    ar = (c == 0 && b inside {4'h7, 4'h2}) || (c == 3 && b[3:2] == 2'b11);
    e.op = expOp(w);
    e.cls = mid_cls_t'(c);
    e.flags.carry = ar || (c == 0 && b inside {4'hD, 4'hC});
    e.flags.digitCarry = ar;
    e.flags.zero = ar || (c == 0 && b inside {4'h5, 4'h4, 4'h6, 4'h9, 4'h3, 4'hA, 4'h1, 4'h8})
      || (c == 3 && b inside {4'h9, 4'h8, 4'hA});
    e.flags.timeoutPowerdown = e.op inside {MID_OP_STANDBY, MID_OP_WATCHDOG_CLEAR};
    e.twoCycle = c == 2 || (c == 3 && b[3:2] == 2'b01) || w == 14'h0008 || w == 14'h0009;
    e.skip = (c == 0 && b inside {4'hB, 4'hF}) ? MID_SK_ZERO :
      (c == 1 && b[3]) ? (b[2] ? MID_SK_SET : MID_SK_CLR) : MID_SK_NONE;
    e.writesReg = (c == 0 && w[7]) || (c == 1 && !b[3]);
    return e;
  endfunction

  // Compare the executing decode with the reference
  task automatic chkDec(input logic [13:0] w);
    ed = expDec(w);
    chk(execDec.op, ed.op);
    chk(execDec.cls, ed.cls);
    chk(execDec.flags, ed.flags);
    chk(execDec.twoCycle, ed.twoCycle);
    chk(execDec.skip, ed.skip);
    chk(execDec.writesReg, ed.writesReg);
    if (w[13:12] == 0) chk(execDec.toReg, w[7]);
    if (w[13:12] == 1 || (w[13:12] == 0 && (w[7] || w[11:9] != 0)))
      chk(execDec.fileAddr, w[6:0]);
    if (w[13:12] == 1) chk(execDec.bitIdx, w[9:7]);
    if (w[13:12] == 2) chk(execDec.literal, w[10:0]);
    if (w[13:12] == 3) chk(execDec.literal[7:0], w[7:0]);
  endtask

  // Main sequence
  initial begin
    errTotal = 0;
    numChecks = 0;
    seed = 53920;
    rst_n = 1'b0;
    apbReq = '0;
    operandByte = 8'h00;
    resultByte = 8'h00;
    for (i = 0; i < 128; i++)
      mid_prog_mem_inst.prog[i] = (i < 35) ? dirW[i] : 14'($random(seed));
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    apb(1'b0, 8'h00, 32'h0);
    chk(rd, 32'h0);
    apb(1'b0, 8'h04, 32'h0);
    chk(rd, 32'h1);
    apb(1'b1, 8'h04, 32'h15);
    apb(1'b0, 8'h04, 32'h0);
    chk(rd, 32'h15);
    apb(1'b0, 8'h10, 32'h0);
    chk(er, 1'b1);
    chk(rd, 32'h0);
    apb(1'b1, 8'h00, 32'h3);
    chk(er, 1'b0);
    cur = -1;
    fl = 1'b0;
    expZ = 1'b0;
    expP = 1'b0;
    pi = 0;
    first = 1'b1;
    waitFetch();
    repeat (120) begin
      if (!first) chk(n, 3);
      first = 1'b0;
      chk(execPhase, 2'h0);
      chk(flushCycle, fl);
      chk(zeroFlag, expZ);
      chk(prescClear, expP);
      if (cur < 0) chk(execDec.op, MID_OP_NOP);
      else chkDec(14'(cur));
      w = mid_prog_mem_inst.prog[pi];
      pi++;
      opB = 8'($random(seed));
      resB = (($random(seed) & 3) == 0) ? 8'h00 : 8'($random(seed));
      @(posedge clk);
      operandByte <= opB;
      resultByte <= resB;
      drop = 1'b0;
      expP = 1'b0;
      // Flushed cycles execute nothing, so they neither skip nor touch flags
      if (cur >= 0) begin
        cw = 14'(cur);
        ed = expDec(cw);
        if (ed.flags.zero) expZ = (resB == 8'h00);
        expP = ed.writesReg && cw[6:0] == 7'h15;
        drop = ed.twoCycle || (ed.skip == MID_SK_ZERO && resB == 8'h00)
          || (ed.skip == MID_SK_CLR && !opB[cw[9:7]])
          || (ed.skip == MID_SK_SET && opB[cw[9:7]]);
      end
      cur = drop ? -1 : int'(w);
      fl = drop;
      waitFetch();
    end
    // Count is latched in phase 2, before the next cycle end: 120 cycles done
    apb(1'b0, 8'h0C, 32'h0);
    chk(rd, 32'h78);
    // Status latched in phase 2 of the cycle after the one that fetched word 120
    apb(1'b0, 8'h08, 32'h0);
    chk({rd[19:18], rd[13:0]}, {2'h2, mid_prog_mem_inst.prog[120]});
    giveVerdict();
  end
endmodule
